// [hw/cisq_pkg.sv]
// constants and state types for the cycle and interrupt sequencer
// assumes one 100 MHz clock, AXI4-Lite register access with 32-bit data
`default_nettype none
package cisq_pkg;
    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_INDEX = 8'h0c;
    localparam logic [7:0] REG_STACK = 8'h10;
    localparam logic [7:0] REG_ACCUM = 8'h14;
    // field positions and reset values
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int CC_MASK_BIT = 4;
    localparam logic [7:0] CC_RESET = 8'h10;
    localparam int ST_WAIT_BIT = 8;
    localparam int ST_NMI_BIT = 9;
    localparam int ST_CYC_LSB = 12;
    // vector pairs, high byte at the even address
    localparam logic [15:0] VEC_IRQ = 16'hfff8;
    localparam logic [15:0] VEC_SOFT = 16'hfffa;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    localparam logic [15:0] VEC_RESTART = 16'hfffe;
    // opcodes handled by this sequencer; all others run as two-cycle no-ops
    localparam logic [7:0] OP_CLI = 8'h0e;
    localparam logic [7:0] OP_SEI = 8'h0f;
    localparam logic [7:0] OP_BRA = 8'h20;
    localparam logic [7:0] OP_JMPX = 8'h6e;
    localparam logic [7:0] OP_HALT_INT = 8'h3e;
    localparam logic [7:0] OP_SOFT_TRAP = 8'h3f;
    // stacking and timing
    localparam logic [2:0] PUSH_LAST = 3'h6;
    localparam logic [3:0] MAX_INSTR_CYCLES = 4'hc;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MACHINE_CYCLE_NS = 20;
    localparam int PHASE_CLKS = MACHINE_CYCLE_NS / (2 * CLK_PERIOD_NS);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SQ_RESET, SQ_FETCH, SQ_OPER, SQ_EXEC, SQ_PUSH, SQ_WAIT, SQ_VEC_HI, SQ_VEC_LO
    } cisq_st_t;
endpackage : cisq_pkg
`default_nettype wire

// [hw/cisq_sequencer.sv]
// cycle control and interrupt/restart sequencing of an 8-bit processor core
// memory on data_in answers within one clock on aclk; pins cross via two flops
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`default_nettype none
// Operation
// - every machine cycle is one phase-one period then one phase-two period
// - each instruction takes between two and twelve machine cycles
// - phase one drives the address, phase two latches the byte read
// - instruction execution takes its own machine cycle, with no bus access, before the next fetch
// - sixteen-bit program counter auto-increments to the next instruction address
// - relative branch adds one signed offset byte to the program counter
// - indexed jump loads index plus fetched unsigned byte into program counter
// - non-maskable falling edge always interrupts, even when masked or servicing
// - non-maskable: finish instruction, stack, set mask, vector from FFFC/FFFD
// - maskable request held low tests mask at instruction end; waits if set
// - accepted maskable request stacks, sets mask, vectors from FFF8/FFF9
// - soft trap instruction stacks, sets mask, vectors from FFFA/FFFB
// - restart rising edge clears registers, sets mask, vectors from FFFE/FFFF
// - every interrupt except restart stacks all visible registers but stack pointer
// - halt-until-interrupt stacks registers then idles until hardware interrupt
// - mask bit four of condition codes blocks the maskable request
// - data drive enable and float control detach data and address buses
// - vector high byte comes from lower address, low byte from next
// - float control high floats address and read line, drops valid and grant
module cisq_sequencer #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // control pins
    input wire logic restart_n,
    input wire logic nmi_n,
    input wire logic irq_n,
    input wire logic addr_float_ctl,
    input wire logic data_drive_en,
    // system bus
    input wire logic [7:0] data_in,
    output logic [15:0] addr_out,
    output logic addr_oe,
    output logic rw_out,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic addr_valid,
    output logic bus_avail
);
    typedef struct packed {
        logic [1:0] rst_s;
        logic [2:0] nmi_s;
        logic [1:0] irq_s;
        logic [1:0] tsc_s;
        logic [1:0] dbe_s;
        cisq_pkg::cisq_st_t st;
        logic ph;
        logic [15:0] pc;
        logic [15:0] x;
        logic [15:0] sp;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] cc;
        logic [7:0] opcode;
        logic [7:0] oper;
        logic [2:0] push_idx;
        logic to_wait;
        logic waiting;
        logic [15:0] vec;
        logic nmi_pend;
        logic [3:0] cyc;
        logic run;
        logic [15:0] addr;
        logic rw;
        logic valid;
        logic valid_out;
        logic oe;
        logic [7:0] dout;
        logic dout_oe;
        logic avail;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } cisq_state_t;

    cisq_state_t r;
    cisq_state_t n;
    logic stall;
    logic tick;
    logic nmi_edge;

    function automatic logic [7:0] push_byte(input logic [2:0] idx, input cisq_state_t s);
        case (idx)
            3'h0: push_byte = s.pc[7:0];
            3'h1: push_byte = s.pc[15:8];
            3'h2: push_byte = s.x[7:0];
            3'h3: push_byte = s.x[15:8];
            3'h4: push_byte = s.a;
            3'h5: push_byte = s.b;
            default: push_byte = s.cc;
        endcase
    endfunction : push_byte

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = strb[i] ? d[8*i +: 8] : old[8*i +: 8];
        end
        merge = old;
    endfunction : merge

    // float holds the phase clocks still, so the sequence freezes rather than losing a write
    assign stall = r.tsc_s[1] | ~r.run;
    assign tick = r.ph & ~stall;
    // edge found on the second and third flops, never the first
    assign nmi_edge = r.nmi_s[2] & ~r.nmi_s[1];

    always_comb begin
        logic [31:0] wv;
        logic irq_ok;
        wv = 32'h0;
        n = r;
        n.rst_s = {r.rst_s[0], restart_n};
        n.nmi_s = {r.nmi_s[1:0], nmi_n};
        n.irq_s = {r.irq_s[0], irq_n};
        n.tsc_s = {r.tsc_s[0], addr_float_ctl};
        n.dbe_s = {r.dbe_s[0], data_drive_en};
        irq_ok = ~r.irq_s[1] & ~r.cc[cisq_pkg::CC_MASK_BIT];
        if (!stall) begin
            n.ph = ~r.ph;
        end
        if (tick) begin
            n.cyc = r.cyc + 4'h1;
            case (r.st)
                cisq_pkg::SQ_FETCH: begin
                    n.opcode = data_in;
                    n.pc = r.pc + 16'h1;
                    n.cyc = 4'h1;
                    n.st = (data_in == cisq_pkg::OP_BRA || data_in == cisq_pkg::OP_JMPX) ?
                           cisq_pkg::SQ_OPER : cisq_pkg::SQ_EXEC;
                end
                cisq_pkg::SQ_OPER: begin
                    n.oper = data_in;
                    n.pc = r.pc + 16'h1;
                    n.st = cisq_pkg::SQ_EXEC;
                end
                cisq_pkg::SQ_EXEC: begin
                    n.st = cisq_pkg::SQ_FETCH;
                    n.push_idx = 3'h0;
                    n.to_wait = 1'b0;
                    case (r.opcode)
                        cisq_pkg::OP_BRA: n.pc = r.pc + {{8{r.oper[7]}}, r.oper};
                        cisq_pkg::OP_JMPX: n.pc = r.x + {8'h00, r.oper};
                        cisq_pkg::OP_CLI: n.cc[cisq_pkg::CC_MASK_BIT] = 1'b0;
                        cisq_pkg::OP_SEI: n.cc[cisq_pkg::CC_MASK_BIT] = 1'b1;
                        default: ;
                    endcase
                    if (r.opcode == cisq_pkg::OP_SOFT_TRAP) begin
                        n.vec = cisq_pkg::VEC_SOFT;
                        n.st = cisq_pkg::SQ_PUSH;
                    end else if (r.opcode == cisq_pkg::OP_HALT_INT) begin
                        n.to_wait = 1'b1;
                        n.st = cisq_pkg::SQ_PUSH;
                    end else if (r.nmi_pend) begin
                        n.nmi_pend = 1'b0;
                        n.vec = cisq_pkg::VEC_NMI;
                        n.st = cisq_pkg::SQ_PUSH;
                    end else if (irq_ok) begin
                        n.vec = cisq_pkg::VEC_IRQ;
                        n.st = cisq_pkg::SQ_PUSH;
                    end
                end
                cisq_pkg::SQ_PUSH: begin
                    n.sp = r.sp - 16'h1;
                    n.push_idx = r.push_idx + 3'h1;
                    if (r.push_idx == cisq_pkg::PUSH_LAST) begin
                        if (r.to_wait) begin
                            n.st = cisq_pkg::SQ_WAIT;
                            n.waiting = 1'b1;
                        end else begin
                            n.cc[cisq_pkg::CC_MASK_BIT] = 1'b1;
                            n.st = cisq_pkg::SQ_VEC_HI;
                        end
                    end
                end
                cisq_pkg::SQ_WAIT: begin
                    // a halt may last any time, so the cycle count pauses here
                    n.cyc = r.cyc;
                    // registers are already stacked, so wake goes straight to the vector
                    if (r.nmi_pend || irq_ok) begin
                        n.nmi_pend = 1'b0;
                        n.vec = r.nmi_pend ? cisq_pkg::VEC_NMI : cisq_pkg::VEC_IRQ;
                        n.cc[cisq_pkg::CC_MASK_BIT] = 1'b1;
                        n.waiting = 1'b0;
                        n.st = cisq_pkg::SQ_VEC_HI;
                    end
                end
                cisq_pkg::SQ_VEC_HI: begin
                    n.pc[15:8] = data_in;
                    n.st = cisq_pkg::SQ_VEC_LO;
                end
                cisq_pkg::SQ_VEC_LO: begin
                    n.pc[7:0] = data_in;
                    n.st = cisq_pkg::SQ_FETCH;
                end
                cisq_pkg::SQ_RESET: begin
                    if (r.rst_s[1]) begin
                        n.a = 8'h00;
                        n.b = 8'h00;
                        n.x = 16'h0000;
                        n.sp = 16'h0000;
                        n.cc = cisq_pkg::CC_RESET;
                        n.vec = cisq_pkg::VEC_RESTART;
                        n.st = cisq_pkg::SQ_VEC_HI;
                    end
                end
                default: n.st = cisq_pkg::SQ_RESET;
            endcase
        end
        if (!r.rst_s[1]) begin
            n.st = cisq_pkg::SQ_RESET;
            n.ph = 1'b0;
            n.waiting = 1'b0;
            n.cyc = 4'h0;
        end
        // next machine cycle's bus operation, set up on the phase-two edge
        if (tick || !r.rst_s[1]) begin
            n.rw = 1'b1;
            n.addr = n.pc;
            n.valid = 1'b0;
            case (n.st)
                cisq_pkg::SQ_FETCH, cisq_pkg::SQ_OPER: n.valid = 1'b1;
                cisq_pkg::SQ_PUSH: begin
                    n.addr = n.sp;
                    n.rw = 1'b0;
                    n.valid = 1'b1;
                    n.dout = push_byte(n.push_idx, n);
                end
                cisq_pkg::SQ_VEC_HI: begin
                    n.addr = n.vec;
                    n.valid = 1'b1;
                end
                cisq_pkg::SQ_VEC_LO: begin
                    n.addr = {n.vec[15:1], 1'b1};
                    n.valid = 1'b1;
                end
                default: ;
            endcase
        end
        n.nmi_pend = n.nmi_pend | nmi_edge;
        n.oe = ~n.tsc_s[1];
        n.dout_oe = n.dbe_s[1] & ~n.rw;
        n.avail = (n.waiting | ~n.run) & ~n.tsc_s[1];
        // the cycle's own valid is kept, so a frozen cycle resumes intact after float
        n.valid_out = n.valid & ~n.tsc_s[1];
        // register bus: address and data taken together, answer one clock later
        n.awready = 1'b0;
        n.wready = 1'b0;
        n.arready = 1'b0;
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_wvalid && !r.awready && !r.bvalid) begin
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        if (r.awready) begin
            n.bvalid = 1'b1;
            n.bresp = cisq_pkg::RESP_OKAY;
            case (s_axi_awaddr[7:0])
                cisq_pkg::REG_CTRL: begin
                    wv = merge({31'h0, r.run}, s_axi_wdata, s_axi_wstrb);
                    n.run = wv[cisq_pkg::CTRL_RUN_BIT];
                end
                cisq_pkg::REG_INDEX: begin
                    wv = merge({16'h0, n.x}, s_axi_wdata, s_axi_wstrb);
                    n.x = wv[15:0];
                end
                cisq_pkg::REG_STACK: begin
                    wv = merge({16'h0, n.sp}, s_axi_wdata, s_axi_wstrb);
                    n.sp = wv[15:0];
                end
                cisq_pkg::REG_ACCUM: begin
                    wv = merge({16'h0, n.b, n.a}, s_axi_wdata, s_axi_wstrb);
                    n.a = wv[7:0];
                    n.b = wv[15:8];
                end
                cisq_pkg::REG_STATUS, cisq_pkg::REG_PC: ;
                default: n.bresp = cisq_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !r.arready && !r.rvalid) begin
            n.arready = 1'b1;
        end
        if (r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = cisq_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                cisq_pkg::REG_CTRL: n.rdata = {31'h0, r.run};
                cisq_pkg::REG_STATUS: n.rdata = {16'h0, r.cyc, 2'h0, r.nmi_pend, r.waiting, r.cc};
                cisq_pkg::REG_PC: n.rdata = {16'h0, r.pc};
                cisq_pkg::REG_INDEX: n.rdata = {16'h0, r.x};
                cisq_pkg::REG_STACK: n.rdata = {16'h0, r.sp};
                cisq_pkg::REG_ACCUM: n.rdata = {16'h0, r.b, r.a};
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = cisq_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= cisq_pkg::SQ_RESET;
            r.nmi_s <= 3'h7;
            r.irq_s <= 2'h3;
            r.cc <= cisq_pkg::CC_RESET;
            r.run <= cisq_pkg::CTRL_RUN_RESET;
            r.rw <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign addr_out = r.addr;
    assign addr_oe = r.oe;
    assign rw_out = r.rw;
    assign data_out = r.dout;
    assign data_oe = r.dout_oe;
    assign addr_valid = r.valid_out;
    assign bus_avail = r.avail;

    a_phase_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (!stall && r.rst_s[1]) |=> (r.ph != $past(r.ph)))
        else $error("phase did not alternate");
    a_instr_len: assert property (@(posedge aclk) disable iff (!aresetn)
        r.cyc <= cisq_pkg::MAX_INSTR_CYCLES)
        else $error("instruction longer than twelve cycles");
    a_fetch_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && r.st == cisq_pkg::SQ_FETCH && r.rst_s[1]) |=> (r.opcode == $past(data_in)))
        else $error("opcode not latched in phase two");
    a_pc_incr: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && r.st == cisq_pkg::SQ_FETCH && r.rst_s[1] && !r.awready)
        |=> (r.pc == $past(r.pc) + 16'h1))
        else $error("program counter did not advance");
    a_branch_target: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && r.st == cisq_pkg::SQ_EXEC && r.opcode == cisq_pkg::OP_BRA && r.rst_s[1])
        |=> (r.pc == $past(r.pc) + {{8{$past(r.oper[7])}}, $past(r.oper)}))
        else $error("relative branch target wrong");
    a_index_jump: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && r.st == cisq_pkg::SQ_EXEC && r.opcode == cisq_pkg::OP_JMPX && r.rst_s[1])
        |=> (r.pc == $past(r.x) + {8'h00, $past(r.oper)}))
        else $error("indexed jump target wrong");
    a_vec_order: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.st == cisq_pkg::SQ_VEC_HI && r.valid) |-> (r.addr == r.vec && !r.addr[0]))
        else $error("vector high byte not at even address");
    a_mask_vec: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.st == cisq_pkg::SQ_VEC_HI) |-> r.cc[cisq_pkg::CC_MASK_BIT])
        else $error("mask clear while vectoring");
    a_float_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        r.tsc_s[1] |-> (!addr_valid && !addr_oe && !bus_avail))
        else $error("bus driven while floated");
    a_nmi_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        nmi_edge |=> r.nmi_pend)
        else $error("non-maskable edge lost");
endmodule : cisq_sequencer
`default_nettype wire

// [bench/cisq_mem_model.sv]
// memory and i/o stand-in on the processor's system bus, logging each access
// assumes addresses stand a whole machine cycle and reads are answered at once
`default_nettype none
module cisq_mem_model (
    // clock
    input wire logic aclk,
    // system bus
    input wire logic [15:0] addr_out,
    input wire logic addr_oe,
    input wire logic rw_out,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic addr_valid,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [logic [15:0]];
    logic [24:0] log_q [$];
    logic [7:0] noise = 8'ha5;
    logic prev_v = 1'b0;
    logic [16:0] prev_key = '0;
    wire logic rd_now = addr_valid && addr_oe && rw_out;
    // unwritten places read as a two-cycle no-op
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 8'h01;
    endfunction : peek
    // bus not read: a moving pattern, so a stale byte is never mistaken for data
    assign data_in = rd_now ? peek(addr_out) : noise;
    always @(posedge aclk) begin
        noise <= noise + 8'h3b;
        if (addr_valid && addr_oe && (!prev_v || prev_key != {rw_out, addr_out})) begin
            log_q.push_back({rw_out, addr_out, rw_out ? data_in : data_out});
        end
        if (addr_valid && !rw_out && data_oe) begin
            mem[addr_out] = data_out;
        end
        prev_v <= addr_valid && addr_oe;
        prev_key <= {rw_out, addr_out};
    end
endmodule : cisq_mem_model
`default_nettype wire

// [bench/test_cpu_cycle_and_interrupt_sequencer.sv]
// self-checking bench: program run, traps, wait, float, register bus
// assumes the memory stand-in logs every valid bus access in order
`default_nettype none
module test_cpu_cycle_and_interrupt_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] IMG [16] = '{24'hfffe10, 24'hffff04, 24'h100c0e, 24'h100d20,
        24'h100ef0, 24'h0fff6e, 24'h1000ff, 24'h20ff3f, 24'hfffa30, 24'hfffb02, 24'h30023e,
        24'hfffc40, 24'hfffd06, 24'h40060e, 24'hfff850, 24'hfff908};
    logic aclk = 1'b0, aresetn = 1'b0, restart_n = 1'b0, nmi_n = 1'b1, irq_n = 1'b1;
    logic float_ctl = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = '0, ara = '0, data_out, data_in;
    logic [31:0] wd = '0, rdt, rnd = 32'h5c6e;
    logic awr, wr, bv, arr, rvl, addr_oe, rw_out, data_oe, addr_valid, bus_avail;
    logic [1:0] brs, rrs, rsp;
    logic [15:0] addr_out, sp, acc;
    logic [24:0] exp_q [$];
    int num_errors = 0, num_checks = 0;
    always #5 aclk = ~aclk;
    cisq_sequencer u_cisq_sequencer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brs),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rvl),
        .s_axi_rready(rry), .restart_n(restart_n), .nmi_n(nmi_n), .irq_n(irq_n),
        .addr_float_ctl(float_ctl), .data_drive_en(1'b1), .data_in(data_in),
        .addr_out(addr_out), .addr_oe(addr_oe), .rw_out(rw_out), .data_out(data_out),
        .data_oe(data_oe), .addr_valid(addr_valid), .bus_avail(bus_avail));
    cisq_mem_model u_cisq_mem_model (.aclk(aclk), .addr_out(addr_out), .addr_oe(addr_oe),
        .rw_out(rw_out), .data_out(data_out), .data_oe(data_oe), .addr_valid(addr_valid),
        .data_in(data_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_access(input int i, input logic [24:0] e);
        logic [24:0] g;
        g = (i >= 0 && i < u_cisq_mem_model.log_q.size()) ? u_cisq_mem_model.log_q[i] : 'x;
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] access %0d expected %h seen %h", i, e, g);
        end
    endtask : check_access
    task automatic hang(input string what);
        num_errors++;
        $display("[FAIL] %s expected answer seen none", what);
        print_verdict();
    endtask : hang
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (awr !== 1'b1 && n < 50);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bv !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        r = brs;
        bry <= 1'b0;
        if (n >= 50) hang("write");
    endtask : axi_write
    // read one register and compare the masked data and the response
    task automatic reg_check(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                             input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arr !== 1'b1 && n < 50);
        arv <= 1'b0;
        while (rvl !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        rry <= 1'b0;
        if (n >= 50) hang("read");
        check_word($sformatf("reg %h data", a), e, rdt & m);
        check_word($sformatf("reg %h resp", a), {30'h0, er}, {30'h0, rrs});
    endtask : reg_check
    task automatic er(input logic [15:0] a, input logic [7:0] d);
        exp_q.push_back({1'b1, a, d});
    endtask : er
    // stacking order: pc low, pc high, index low, index high, a, b, condition codes
    task automatic push7(input logic [15:0] pc, input logic [7:0] cc);
        logic [7:0] b [7];
        b = '{pc[7:0], pc[15:8], 8'h00, 8'h20, acc[7:0], acc[15:8], cc};
        foreach (b[i]) begin
            exp_q.push_back({1'b0, sp, b[i]});
            sp--;
        end
    endtask : push7
    initial begin
        int i, k, nmi_cnt, n;
        foreach (IMG[j]) u_cisq_mem_model.mem[IMG[j][23:8]] = IMG[j][7:0];
        rnd = lfsr(rnd);
        acc = rnd[15:0];
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        reg_check(cisq_pkg::REG_STATUS, 32'hff, 32'h10, cisq_pkg::RESP_OKAY);
        reg_check(8'h40, 32'hffffffff, 32'h0, cisq_pkg::RESP_SLVERR);
        repeat (10) @(posedge aclk);
        restart_n <= 1'b1;
        $display("test reset done");
        repeat (6) @(posedge aclk);
        axi_write(cisq_pkg::REG_INDEX, 32'h2000, rsp);
        axi_write(cisq_pkg::REG_STACK, 32'h01ff, rsp);
        axi_write(cisq_pkg::REG_ACCUM, {16'h0, acc}, rsp);
        axi_write(cisq_pkg::REG_PC, 32'h7777, rsp);
        check_word("pc write resp", 32'h0, {30'h0, rsp});
        axi_write(8'h44, 32'h1, rsp);
        check_word("unmapped write resp", 32'h2, {30'h0, rsp});
        $display("test setup done");
        n = 0;
        while (bus_avail !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 400) hang("halt");
        reg_check(cisq_pkg::REG_STATUS, 32'h100, 32'h100, cisq_pkg::RESP_OKAY);
        irq_n <= 1'b0;
        repeat (20) @(posedge aclk);
        check_word("masked wake", 32'h1, {31'h0, bus_avail});
        nmi_n <= 1'b0;
        repeat (30) @(posedge aclk);
        nmi_n <= 1'b1;
        repeat (300) @(posedge aclk);
        $display("test wait done");
        sp = 16'h01ff;
        er(cisq_pkg::VEC_RESTART, 8'h10);
        er(cisq_pkg::VEC_RESTART + 16'h1, 8'h04);
        for (i = 0; i < 8; i++) er(16'h1004 + 16'(i), 8'h01);
        er(16'h100c, cisq_pkg::OP_CLI);
        er(16'h100d, cisq_pkg::OP_BRA);
        er(16'h100e, 8'hf0);
        er(16'h100f + {{8{1'b1}}, 8'hf0}, cisq_pkg::OP_JMPX);
        er(16'h1000, 8'hff);
        er(16'h2000 + 16'h00ff, cisq_pkg::OP_SOFT_TRAP);
        push7(16'h2100, 8'h00);
        er(cisq_pkg::VEC_SOFT, 8'h30);
        er(cisq_pkg::VEC_SOFT + 16'h1, 8'h02);
        er(16'h3002, cisq_pkg::OP_HALT_INT);
        push7(16'h3003, 8'h10);
        er(cisq_pkg::VEC_NMI, 8'h40);
        er(cisq_pkg::VEC_NMI + 16'h1, 8'h06);
        er(16'h4006, cisq_pkg::OP_CLI);
        foreach (exp_q[j]) check_access(j, exp_q[j]);
        k = -1;
        nmi_cnt = 0;
        for (i = 0; i < u_cisq_mem_model.log_q.size(); i++) begin
            if (k < 0 && u_cisq_mem_model.log_q[i][24:8] == {1'b1, cisq_pkg::VEC_IRQ}) k = i;
            if (u_cisq_mem_model.log_q[i][24:8] == {1'b1, cisq_pkg::VEC_NMI}) nmi_cnt++;
        end
        check_word("nmi entries", 32'h1, nmi_cnt);
        check_access(k - 1, {1'b0, 16'(sp - 16'h6), 8'h00});
        check_access(k + 1, {1'b1, cisq_pkg::VEC_IRQ + 16'h1, 8'h08});
        check_access(k + 2, {1'b1, 16'h5008, 8'h01});
        irq_n <= 1'b1;
        $display("test trace done");
        float_ctl <= 1'b1;
        // two sync flops pass before the bus lets go; accesses until then are legal
        repeat (3) @(posedge aclk);
        n = u_cisq_mem_model.log_q.size();
        repeat (17) @(posedge aclk);
        check_word("float outs", 32'h0, {addr_oe, addr_valid, bus_avail});
        check_word("float log", n, u_cisq_mem_model.log_q.size());
        float_ctl <= 1'b0;
        repeat (10) @(posedge aclk);
        check_word("unfloat", 32'h1, {31'h0, addr_oe});
        $display("test float done");
        print_verdict();
    end
endmodule : test_cpu_cycle_and_interrupt_sequencer
`default_nettype wire
